// ---- bench/e1oh_far_end.sv ----
//==========================================================
// Far end E1 transmitter model
//==========================================================
// Purpose: Hands received TS0 and TS16 bytes to the block
// Assumes: One byte per call, strobe one hclk wide
// Notes: Idle byte lines carry the inverse of the last byte
`timescale 1ns/1ps
module e1oh_far_end
(
  input wire logic hclk,
  output logic ts0_valid,
  output logic ts0_is_nfas,
  output logic [7:0] ts0_byte,
  output logic ts16_valid,
  output logic [7:0] ts16_byte
);
  // Quiet lines before the first byte
  initial {ts0_valid, ts0_is_nfas, ts0_byte, ts16_valid, ts16_byte} = '0;
  // Stale data is inverted so it never passes for a fresh byte
  task send(input logic t16, input logic nfas, input logic [7:0] b);
    @(posedge hclk);
    ts0_valid <= !t16;
    ts16_valid <= t16;
    ts0_is_nfas <= nfas;
    ts0_byte <= b;
    ts16_byte <= b;
    @(posedge hclk);
    ts0_valid <= 1'b0;
    ts16_valid <= 1'b0;
    ts0_byte <= ~b;
    ts16_byte <= ~b;
  endtask : send
endmodule : e1oh_far_end

// ---- bench/e1oh_overhead_irq_chk.sv ----
//==========================================================
// Port checks of the overhead block
//==========================================================
// Purpose: Bus answer and interrupt pin relations
// Assumes: clk_en held high
// Notes: Register contents are judged by the bench
`timescale 1ns/1ps
module e1oh_overhead_irq_chk
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic basic_frame_loss_status,
  input wire logic irq
);
  wire acc = hsel && htrans[1] && hready;
  wire wr = acc && hwrite;
  wire rd = acc && !hwrite;
  logic wrote; // Any write since reset; enables start cleared
  // Remembers the first register write
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wrote <= 1'b0;
    else if (wr)
      wrote <= 1'b1;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("wait state seen");
  a_rdata_hold: assert property (!$past(rd) |-> $stable(hrdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd && haddr[7:0] > 8'h24 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_loss_implied: assert property (rd && haddr[7:0] == 8'h00 &&
    basic_frame_loss_status && $past(basic_frame_loss_status) |=> hrdata[3:1] == 3'b111)
    else $error("frame loss not seen in multiframe losses");
  a_irq_quiet: assert property (!wrote |-> !irq)
    else $error("irq without enable");
  a_irq_clear_write: assert property ($fell(irq) |-> $past(wr, 3))
    else $error("irq fell without a write");
  a_irq_sticky: assert property (!wr ##2 irq |=> irq)
    else $error("irq dropped on its own");
endmodule : e1oh_overhead_irq_chk
bind e1oh_overhead_irq e1oh_overhead_irq_chk CHK (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .basic_frame_loss_status, .irq);

// ---- bench/e1oh_overhead_irq_tb_top.sv ----
//==========================================================
// Overhead block bench
//==========================================================
// Purpose: Self-checking run over capture, codewords and flags
// Assumes: Zero-wait single slave, clk_en held high
// Notes: Reads queue their expectation, a monitor compares
`timescale 1ns/1ps
module e1oh_overhead_irq_tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_dp = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [6:0] st = '0; // Status levels
  logic [10:0] ev = '0; // Event and start pulses
  logic hreadyout, hresp, irq, ts0_valid, ts0_is_nfas, ts16_valid;
  logic [7:0] ts0_byte, ts16_byte;
  logic [31:0] hrdata, r, s, c, e;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [7:0] ra[10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h40};
  logic [31:0] rv[10] = '{0, 0, 0, 0, 0, 0, 32'hff, 32'hf, 32'hfffff, 0};
  logic [11:0] cd[5] = '{12'h888, 12'haaa, 12'hccc, 12'heee, 12'hfff};
  logic [7:0] lk[4] = '{8'h02, 8'h02, 8'h00, 8'h00};
  logic [31:0] lx[4] = '{32'h80, 32'h0, 32'h0, 32'h80};
  int ei[9] = '{0, 1, 2, 3, 4, 5, 8, 9, 10};
  always #50 hclk = ~hclk;
  e1oh_overhead_irq DUT (.hclk, .hresetn, .clk_en(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .ts0_valid,
    .ts0_is_nfas, .ts0_byte, .ts16_valid, .ts16_byte, .crc_mf_start(ev[8]),
    .crc_submf_start(ev[9]), .sig_mf_start(ev[10]), .interworking_status(st[0]),
    .basic_frame_loss_status(st[1]), .crc_multiframe_loss_status(st[2]),
    .signaling_multiframe_loss_status(st[3]), .offline_search_status(st[4]),
    .alarm_and_block_error_status(st[5]), .persistent_block_error_status(st[6]),
    .alignment_moved(ev[0]), .frame_word_error(ev[1]), .crc_mf_pattern_error(ev[2]),
    .sig_mf_pattern_error(ev[3]), .checksum_error(ev[4]), .far_block_error(ev[5]), .irq);
  e1oh_far_end FE (.hclk, .ts0_valid, .ts0_is_nfas, .ts0_byte, .ts16_valid, .ts16_byte);
  task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task tally_and_finish;
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // One single transfer; a read queues its masked expectation
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
           input logic [31:0] m = '1);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp <= !wr;
    if (!wr)
    begin
      q_exp.push_back(d & m);
      q_msk.push_back(m);
    end
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask : bus
  task pulse(input int i);
    @(posedge hclk);
    ev[i] <= 1'b1;
    @(posedge hclk);
    ev <= '0;
  endtask : pulse
  // Four NFAS frames, first received bit is the codeword MSB
  task submf(input logic [19:0] cw);
    for (int k = 0; k < 4; k++)
      FE.send(0, 1, {3'h0, cw[3 - k], cw[7 - k], cw[11 - k], cw[15 - k], cw[19 - k]});
    pulse(9);
  endtask : submf
  // Oldest note against each read result
  always @(posedge hclk)
    if (rd_dp && hreadyout)
      check("hrdata", hrdata & q_msk.pop_front(), q_exp.pop_front());
  // A hang ends the run as a failure
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  initial
  begin
    void'($urandom(42));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ra[i])
      bus(0, ra[i], rv[i]);
    r = $urandom;
    s = $urandom;
    FE.send(0, 1, r[7:0]);
    FE.send(0, 0, s[7:0]);
    e = {24'h0, r[4:0], r[5], r[7], s[7]};
    bus(0, 8'h18, e);
    FE.send(1, 0, s[7:0]);
    pulse(10);
    bus(0, 8'h1c, {28'h0, s[2], s[3], s[1], s[0]});
    // Frame loss freezes overhead and spare alike
    st[1] <= 1'b1;
    FE.send(0, 1, ~r[7:0]);
    FE.send(1, 0, ~s[7:0]);
    pulse(10);
    bus(0, 8'h18, e);
    bus(0, 8'h1c, {28'h0, s[2], s[3], s[1], s[0]});
    st[1] <= 1'b0;
    pulse(9);
    c = $urandom;
    submf(c[19:0]);
    bus(0, 8'h20, {12'h0, c[19:0]});
    e = '0;
    for (int p = 0; p < 5; p++)
      e[11 + p] = c[4 * p +: 4] != 4'hf;
    bus(0, 8'h0c, e, 32'h1f << 11);
    bus(1, 8'h0c, '1);
    bus(1, 8'h14, 32'h1);
    submf(~c[19:0]);
    bus(0, 8'h20, {12'h0, c[19:0]});
    submf(~c[19:0]);
    bus(0, 8'h20, {12'h0, ~c[19:0]});
    bus(0, 8'h0c, 32'h1f << 11, 32'h1f << 11);
    st[2] <= 1'b1;
    submf(c[19:0]);
    submf(c[19:0]);
    bus(0, 8'h20, {12'h0, ~c[19:0]});
    st[2] <= 1'b0;
    bus(1, 8'h14, 32'h0);
    pulse(9);
    for (int v = 1; v < 4; v++)
    begin
      bus(1, 8'h0c, '1);
      submf({8'h0, v[3:0], 8'h0});
      bus(0, 8'h0c, {24'h0, v[1:0], 6'h0}, 32'hc0);
    end
    // Codeword compare ignores the misaligned 888 that bit mode would see
    bus(1, 8'h14, 32'h2);
    bus(1, 8'h24, '1);
    repeat (4) submf(20'h00100);
    bus(0, 8'h24, 32'h0, 32'h1f);
    repeat (3) submf(20'h00800);
    bus(0, 8'h24, 32'h1, 32'h1);
    bus(1, 8'h14, 32'h0);
    foreach (cd[k])
    begin
      for (int j = 11; j >= 0; j--)
        FE.send(0, 1, {5'h0, cd[k][j], 2'h0});
      bus(0, 8'h24, 32'h1 << k, 32'h1 << k);
      bus(1, 8'h24, '1);
    end
    bus(0, 8'h0c, 32'h10000, 32'h10000);
    bus(1, 8'h10, 32'h10000);
    repeat (2) @(posedge hclk);
    check("irq", {31'h0, irq}, 32'h1);
    bus(1, 8'h0c, 32'h10000);
    repeat (2) @(posedge hclk);
    check("irq", {31'h0, irq}, 32'h0);
    bus(1, 8'h10, 32'h0);
    foreach (lk[k])
    begin
      FE.send(0, 1, lk[k]);
      bus(0, 8'h00, lx[k], 32'h80);
    end
    st[1] <= 1'b1;
    repeat (3) FE.send(0, 1, 8'h02);
    bus(0, 8'h00, 32'h80, 32'h80);
    bus(0, 8'h04, 32'h80, 32'h80);
    st[1] <= 1'b0;
    for (int i = 0; i < 7; i++)
    begin
      bus(1, 8'h04, '1);
      st[i] <= 1'b1;
      bus(0, 8'h00, 32'h1 << i, 32'h1 << i);
      bus(0, 8'h04, 32'h1 << i, 32'h1 << i);
      bus(1, 8'h04, 32'h1 << i);
      st[i] <= 1'b0;
      bus(0, 8'h04, 32'h1 << i, 32'h1 << i);
    end
    foreach (ei[j])
    begin
      pulse(ei[j]);
      bus(0, 8'h0c, 32'h1 << ei[j], 32'h1 << ei[j]);
      check("irq", {31'h0, irq}, 32'h0);
      bus(1, 8'h0c, 32'h1 << ei[j]);
      bus(0, 8'h0c, 32'h0, 32'h1 << ei[j]);
    end
    tally_and_finish();
  end
endmodule : e1oh_overhead_irq_tb_top

// ---- hw/e1oh_cfg.svh ----
//==========================================================
// E1 overhead extraction and event reporting constants
//==========================================================
// Purpose: Register map, field positions, reset values, codes
// Assumes: Included by the overhead extraction block only
// Notes: All offsets are byte addresses of aligned words
`ifndef E1OH_CFG_SVH
`define E1OH_CFG_SVH

// Register byte offsets
`define E1OH_OFF_STATUS 8'h00
`define E1OH_OFF_STAT_FLAG 8'h04
`define E1OH_OFF_STAT_EN 8'h08
`define E1OH_OFF_EVT_FLAG 8'h0c
`define E1OH_OFF_EVT_EN 8'h10
`define E1OH_OFF_CTRL 8'h14
`define E1OH_OFF_OVERHEAD 8'h18
`define E1OH_OFF_SPARE 8'h1c
`define E1OH_OFF_CODEWORD 8'h20
`define E1OH_OFF_CODE_IND 8'h24

// Control register bits
`define E1OH_CTRL_DEBOUNCE 0
`define E1OH_CTRL_SYNC_CMP 1

// Event flag positions
`define E1OH_EVT_CW_LSB 11
`define E1OH_EVT_SPECIAL 16

// Received byte bit positions, bit 1 on the line is bit 7
`define E1OH_TS0_SI 7
`define E1OH_TS0_A 5
`define E1OH_TS0_SA6 2
`define E1OH_TS0_SA7 1
`define E1OH_TS16_Y 2

// Reset values
`define E1OH_RST_STAT_EN 8'h00
`define E1OH_RST_EVT_EN 17'h00000
`define E1OH_RST_CTRL 2'h0
`define E1OH_RST_OVERHEAD 8'hff
`define E1OH_RST_SPARE 4'hf
`define E1OH_RST_CW 4'hf

// Sa6 special codes
`define E1OH_CODE_8 12'h888
`define E1OH_CODE_A 12'haaa
`define E1OH_CODE_C 12'hccc
`define E1OH_CODE_E 12'heee
`define E1OH_CODE_F 12'hfff

// Terminal error codewords on Sa6
`define E1OH_NT_FEBE 4'h1
`define E1OH_NT_CRC 4'h2
`define E1OH_NT_BOTH 4'h3

// Window fill counts
`define E1OH_SA6_FULL 4'hb
`define E1OH_CW_FULL 2'h2
`define E1OH_SA7_FULL 2'h2

`endif

// ---- hw/e1oh_overhead_irq.sv ----
//==========================================================
// E1 receive overhead extraction with event reporting
//==========================================================
// Purpose: Capture TS0/TS16 overhead, detect Sa6/Sa7 patterns,
//          gather framer status and events into flags and irq
// Assumes: Framer pulses are one hclk wide, qualified by clk_en
// Notes: A TS0 byte and a submultiframe start never coincide
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "e1oh_cfg.svh"
module e1oh_overhead_irq
  import e1oh_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic ts0_valid,
  input wire logic ts0_is_nfas,
  input wire logic [7:0] ts0_byte,
  input wire logic ts16_valid,
  input wire logic [7:0] ts16_byte,
  input wire logic crc_mf_start,
  input wire logic crc_submf_start,
  input wire logic sig_mf_start,
  input wire logic interworking_status,
  input wire logic basic_frame_loss_status,
  input wire logic crc_multiframe_loss_status,
  input wire logic signaling_multiframe_loss_status,
  input wire logic offline_search_status,
  input wire logic alarm_and_block_error_status,
  input wire logic persistent_block_error_status,
  input wire logic alignment_moved,
  input wire logic frame_word_error,
  input wire logic crc_mf_pattern_error,
  input wire logic sig_mf_pattern_error,
  input wire logic checksum_error,
  input wire logic far_block_error,
  output logic irq
);

  //==========================================================
  // Decoding helpers
  //==========================================================
  // One bit per special code that the window equals
  function automatic e1oh_code_type code_match(input logic [11:0] w);
    code_match = {w == `E1OH_CODE_F, w == `E1OH_CODE_E,
                  w == `E1OH_CODE_C, w == `E1OH_CODE_A,
                  w == `E1OH_CODE_8};
  endfunction : code_match

  //==========================================================
  // Sync qualifiers
  //==========================================================
  logic frame_ok; // Basic frame aligned
  logic crc_ok; // CRC multiframe aligned, frame loss included
  logic sig_ok; // Signaling multiframe aligned
  logic nfas_take; // Usable NFAS byte this cycle
  logic submf_take; // Usable submultiframe boundary

  assign frame_ok = ~basic_frame_loss_status;
  assign crc_ok = frame_ok & ~crc_multiframe_loss_status;
  assign sig_ok = frame_ok & ~signaling_multiframe_loss_status;
  assign nfas_take = ts0_valid & ts0_is_nfas & frame_ok;
  assign submf_take = crc_submf_start & crc_ok;

  //==========================================================
  // AHB-Lite slave
  //==========================================================
  logic addr_take; // Valid address phase accepted
  logic wr_pend; // Write data phase pending
  logic [7:0] wr_addr; // Latched write offset
  logic [31:0] rd_word; // Read mux output
  logic e_ctrl; // Write strobes per register
  logic e_stat_en;
  logic e_evt_en;
  logic e_stat_clr;
  logic e_evt_clr;
  logic e_code_clr;

  assign addr_take = hsel & htrans[1] & hready;
  assign e_ctrl = wr_pend & (wr_addr == `E1OH_OFF_CTRL);
  assign e_stat_en = wr_pend & (wr_addr == `E1OH_OFF_STAT_EN);
  assign e_evt_en = wr_pend & (wr_addr == `E1OH_OFF_EVT_EN);
  assign e_stat_clr = wr_pend & (wr_addr == `E1OH_OFF_STAT_FLAG);
  assign e_evt_clr = wr_pend & (wr_addr == `E1OH_OFF_EVT_FLAG);
  assign e_code_clr = wr_pend & (wr_addr == `E1OH_OFF_CODE_IND);

  // Address phase capture; zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_pend <= addr_take & hwrite;
      wr_addr <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data is sampled in the address phase so it is a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (clk_en && addr_take && !hwrite)
      hrdata <= rd_word;
  end

  //==========================================================
  // Control and enable registers
  //==========================================================
  logic [1:0] ctrl; // Debounce and sync compare controls
  e1oh_stat_type stat_en; // Status flag enables
  e1oh_evt_type evt_en; // Event flag enables

  // Software writable settings
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= `E1OH_RST_CTRL;
      stat_en <= `E1OH_RST_STAT_EN;
      evt_en <= `E1OH_RST_EVT_EN;
    end
    else if (clk_en)
    begin
      if (e_ctrl)
        ctrl <= hwdata[1:0];
      if (e_stat_en)
        stat_en <= hwdata[7:0];
      if (e_evt_en)
        evt_en <= hwdata[16:0];
    end
  end

  //==========================================================
  // TS0 overhead capture
  //==========================================================
  logic [7:0] overhead; // {Sa4..Sa8, A, Si nfas, Si fas}

  // Out of frame the byte is not trusted, so all fields hold
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      overhead <= `E1OH_RST_OVERHEAD;
    else if (clk_en && ts0_valid && frame_ok)
    begin
      if (ts0_is_nfas)
      begin
        overhead[1] <= ts0_byte[`E1OH_TS0_SI];
        overhead[2] <= ts0_byte[`E1OH_TS0_A];
        overhead[7:3] <= ts0_byte[4:0];
      end
      else
        overhead[0] <= ts0_byte[`E1OH_TS0_SI];
    end
  end

  //==========================================================
  // TS16 spare bits
  //==========================================================
  logic [3:0] spare_hold; // Frame 0 bits waiting for next start
  logic spare_full; // A frame 0 byte has been seen
  logic [3:0] spare; // {Y, X0, X1, X2}

  // Bits are captured in frame 0 but published one start later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      spare_hold <= `E1OH_RST_SPARE;
      spare_full <= 1'b0;
      spare <= `E1OH_RST_SPARE;
    end
    else if (clk_en)
    begin
      if (!sig_ok)
        spare_full <= 1'b0;
      else if (ts16_valid)
      begin
        spare_hold <= {ts16_byte[`E1OH_TS16_Y], ts16_byte[3], ts16_byte[1:0]};
        spare_full <= 1'b1;
      end
      else if (sig_mf_start && spare_full)
        spare <= spare_hold;
    end
  end

  //==========================================================
  // National codewords
  //==========================================================
  logic submf_seen; // Assembly spans a whole submultiframe
  e1oh_cw_type cw_now [5]; // Codeword just completed
  e1oh_cw_type cw_store [5]; // Published codewords
  logic [4:0] cw_chg; // Change pulse per position

  // First boundary after sync only starts the assembly
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      submf_seen <= 1'b0;
    else if (clk_en)
    begin
      if (!crc_ok)
        submf_seen <= 1'b0;
      else if (crc_submf_start)
        submf_seen <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1)
    begin : g_cw
      e1oh_cw_type assy; // Shifting codeword, first bit MSB
      e1oh_cw_type last; // Previous raw codeword
      logic chg; // Stored value changed
      assign cw_now[gi] = assy;
      assign cw_chg[gi] = chg;

      // Shift one Sa bit per NFAS frame
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
          assy <= `E1OH_RST_CW;
        else if (clk_en && nfas_take)
          assy <= {assy[2:0], ts0_byte[4 - gi]};
      end

      // Publish at boundary; debounce trades one submf of latency
      always_ff @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          last <= `E1OH_RST_CW;
          cw_store[gi] <= `E1OH_RST_CW;
          chg <= 1'b0;
        end
        else if (clk_en)
        begin
          chg <= 1'b0;
          if (submf_take && submf_seen)
          begin
            last <= assy;
            if ((!ctrl[`E1OH_CTRL_DEBOUNCE] || assy == last)
                && assy != cw_store[gi])
            begin
              cw_store[gi] <= assy;
              chg <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  //==========================================================
  // Sa6 special code detection
  //==========================================================
  logic cw_mode; // Compare whole codewords instead of bits
  logic [11:0] sa6_bits; // Sliding bit window
  logic [3:0] sa6_fill; // Bits in window minus one, saturating
  logic [11:0] sa6_cws; // Last three codewords
  logic [1:0] cw_fill; // Codewords in window minus one
  e1oh_code_type code_hit; // Match this cycle
  logic [11:0] next_sa6_bits;
  logic [11:0] next_sa6_cws;

  assign cw_mode = crc_ok & ctrl[`E1OH_CTRL_SYNC_CMP];
  assign next_sa6_bits = {sa6_bits[10:0], ts0_byte[`E1OH_TS0_SA6]};
  assign next_sa6_cws = {sa6_cws[7:0], cw_now[2]};

  // Only full windows are compared, so a partial fill never hits
  always_comb
  begin
    code_hit = 5'h00;
    if (!cw_mode && nfas_take && sa6_fill == `E1OH_SA6_FULL)
      code_hit = code_match(next_sa6_bits);
    else if (cw_mode && submf_take && submf_seen && cw_fill == `E1OH_CW_FULL)
      code_hit = code_match(next_sa6_cws);
  end

  // Windows restart whenever their alignment is lost
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sa6_bits <= 12'h000;
      sa6_fill <= 4'h0;
      sa6_cws <= 12'h000;
      cw_fill <= 2'h0;
    end
    else if (clk_en)
    begin
      if (!frame_ok || cw_mode)
        sa6_fill <= 4'h0;
      else if (nfas_take)
      begin
        sa6_bits <= next_sa6_bits;
        if (sa6_fill != `E1OH_SA6_FULL)
          sa6_fill <= sa6_fill + 4'h1;
      end
      if (!cw_mode)
        cw_fill <= 2'h0;
      else if (submf_take && submf_seen)
      begin
        sa6_cws <= next_sa6_cws;
        if (cw_fill != `E1OH_CW_FULL)
          cw_fill <= cw_fill + 2'h1;
      end
    end
  end

  //==========================================================
  // Terminal errors from Sa6 codeword
  //==========================================================
  logic nt_febe; // Terminal far end block error event
  logic nt_crc; // Terminal checksum error event

  always_comb
  begin
    nt_febe = 1'b0;
    nt_crc = 1'b0;
    if (submf_take && submf_seen)
    begin
      nt_febe = cw_now[2] == `E1OH_NT_FEBE || cw_now[2] == `E1OH_NT_BOTH;
      nt_crc = cw_now[2] == `E1OH_NT_CRC || cw_now[2] == `E1OH_NT_BOTH;
    end
  end

  //==========================================================
  // Link ID detection on Sa7
  //==========================================================
  logic [2:0] sa7_bits; // Sliding three bit window
  logic [1:0] sa7_fill; // Bits in window minus one
  logic link_id_status; // Two of three zero
  logic [2:0] next_sa7_bits;

  assign next_sa7_bits = {sa7_bits[1:0], ts0_byte[`E1OH_TS0_SA7]};

  // Out of frame the status holds and the window refills later
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sa7_bits <= 3'h7;
      sa7_fill <= 2'h0;
      link_id_status <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!frame_ok)
        sa7_fill <= 2'h0;
      else if (nfas_take)
      begin
        sa7_bits <= next_sa7_bits;
        if (sa7_fill != `E1OH_SA7_FULL)
          sa7_fill <= sa7_fill + 2'h1;
        else
          link_id_status <= (~next_sa7_bits[0] & ~next_sa7_bits[1]) |
                            (~next_sa7_bits[0] & ~next_sa7_bits[2]) |
                            (~next_sa7_bits[1] & ~next_sa7_bits[2]);
      end
    end
  end

  //==========================================================
  // Status sources and their change flags
  //==========================================================
  e1oh_stat_type stat_now; // Live status vector
  e1oh_stat_type stat_prev; // Status one cycle ago
  e1oh_stat_type stat_flag; // Sticky change flags

  assign stat_now = {link_id_status, persistent_block_error_status,
                     alarm_and_block_error_status, offline_search_status,
                     ~sig_ok, ~crc_ok, basic_frame_loss_status,
                     interworking_status};

  // Set beats a same-cycle write clear so no edge is lost
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      stat_prev <= 8'h00;
      stat_flag <= 8'h00;
    end
    else if (clk_en)
    begin
      stat_prev <= stat_now;
      stat_flag <= (stat_flag & ~(e_stat_clr ? hwdata[7:0] : 8'h00)) |
                   (stat_now ^ stat_prev);
    end
  end

  //==========================================================
  // Event-only flags and Sa6 code indication
  //==========================================================
  e1oh_evt_type evt_set; // Events this cycle
  e1oh_evt_type evt_flag; // Sticky event flags
  e1oh_code_type code_ind; // Sticky per code match

  assign evt_set = {|code_hit, cw_chg, sig_mf_start, crc_submf_start,
                    crc_mf_start, nt_crc, nt_febe, far_block_error,
                    checksum_error, sig_mf_pattern_error,
                    crc_mf_pattern_error, frame_word_error,
                    alignment_moved};

  // Write one to clear; new events win over the clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      evt_flag <= 17'h00000;
      code_ind <= 5'h00;
    end
    else if (clk_en)
    begin
      evt_flag <= (evt_flag & ~(e_evt_clr ? hwdata[16:0] : 17'h00000)) |
                  evt_set;
      code_ind <= (code_ind & ~(e_code_clr ? hwdata[4:0] : 5'h00)) |
                  code_hit;
    end
  end

  //==========================================================
  // Interrupt output
  //==========================================================
  // Registered so the pin is glitch free
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq <= 1'b0;
    else if (clk_en)
      irq <= |(stat_flag & stat_en) | |(evt_flag & evt_en);
  end

  //==========================================================
  // Read mux
  //==========================================================
  // Unmapped offsets read as zero
  always_comb
  begin
    rd_word = 32'h00000000;
    unique case (haddr[7:0])
      `E1OH_OFF_STATUS: rd_word[7:0] = stat_now;
      `E1OH_OFF_STAT_FLAG: rd_word[7:0] = stat_flag;
      `E1OH_OFF_STAT_EN: rd_word[7:0] = stat_en;
      `E1OH_OFF_EVT_FLAG: rd_word[16:0] = evt_flag;
      `E1OH_OFF_EVT_EN: rd_word[16:0] = evt_en;
      `E1OH_OFF_CTRL: rd_word[1:0] = ctrl;
      `E1OH_OFF_OVERHEAD: rd_word[7:0] = overhead;
      `E1OH_OFF_SPARE: rd_word[3:0] = spare;
      `E1OH_OFF_CODEWORD: rd_word[19:0] = {cw_store[4], cw_store[3], cw_store[2],
                                           cw_store[1], cw_store[0]};
      `E1OH_OFF_CODE_IND: rd_word[4:0] = code_ind;
      default: rd_word = 32'h00000000;
    endcase
  end

endmodule : e1oh_overhead_irq

// ---- hw/e1oh_pkg.sv ----
//==========================================================
// E1 overhead extraction types
//==========================================================
// Purpose: Shared types of the overhead extraction block
// Assumes: Constants live in e1oh_cfg.svh
// Notes: Types only
package e1oh_pkg;
  // One four-bit national codeword
  typedef logic [3:0] e1oh_cw_type;
  // Eight status sources
  typedef logic [7:0] e1oh_stat_type;
  // Event-only flags, start flags, codeword and code flags
  typedef logic [16:0] e1oh_evt_type;
  // One flag per special Sa6 code
  typedef logic [4:0] e1oh_code_type;
endpackage : e1oh_pkg
